// File: dps_host.sv
// Host controller that drives one port of a dual-port semaphore flag bank.
`timescale 1ns/1ps
`include "dps_map.svh"
// ==========================================================================
// Overview of operation
// [RQ1] The device holds eight flags apart from its memory array.
// [RQ2] Flag space is reached with its select low, strobes as for static memory.
// [RQ3] Only address bits zero to two pick the flag; higher bits are ignored.
// [RQ4] A flag write uses only data bit zero.
// [RQ5] Flags are active low: write zero to request, one to release.
// [RQ6] A zero into a free flag reads zero here, one on the far port.
// [RQ7] Owner writing one frees the flag unless the far port has a request.
// [RQ8] A non-owner zero waits in that port's request latch.
// [RQ9] A pending far request takes the token as soon as the owner releases.
// [RQ10] A flag read shows the flag value on every data bit.
// [RQ11] Read data is latched while select and output enable stay low.
// [RQ12] Between polling reads, select and output enable are raised again.
// [RQ13] Colliding requests grant exactly one port, earlier one first.
// [RQ14] Acquire is write zero then read back, never read then write.
// [RQ15] A failed request keeps polling or writes one to withdraw.
// [RQ16] Flags and request latches are not set up at power-on.
// [RQ17] At start-up the host writes one to all eight flags.
// [RQ18] Both enables high puts the device port into standby.
// [RQ19] Flags never block memory access nor add wait states.
// [RQ20] In flag space the memory chip enable is held high.
// [RQ21] Data width is sixteen or eighteen bits, all replicated on read.
// ==========================================================================
module dps_host
   import dps_pkg::*;
#(
   parameter int DATA_W = 18,
   parameter int ADDR_W = 13,
   parameter int POLLS  = `DPS_POLLS_DEF
)
(
   input  wire logic              clk_sys_i,
   input  wire logic              sys_rst_i,
   input  wire logic              cmd_valid_i,
   input  wire dps_op_t           cmd_op_i,
   input  wire logic [2:0]        cmd_idx_i,
   output logic                   cmd_ready_o,
   output logic                   done_o,
   output logic                   granted_o,
   output logic [DATA_W-1:0]      flag_data_o,
   output logic                   token_space_select_n_o,
   output logic                   mem_ce_n_o,
   output logic                   oe_n_o,
   output logic                   rw_n_o,
   output logic [ADDR_W-1:0]      addr_o,
   output logic [DATA_W-1:0]      data_o,
   output logic                   data_oe_o,
   input  wire logic [DATA_W-1:0] data_i
);

   // ========================================================================
   // Parameter checks; a value the logic cannot serve stops elaboration.
   if (DATA_W != 16 && DATA_W != 18)
   begin : g_bad_width
      $error("DATA_W must be 16 or 18.");
   end
   if (ADDR_W < 3)
   begin : g_bad_addr
      $error("ADDR_W must cover the three flag address bits.");
   end
   if (POLLS < 0 || POLLS > 255)
   begin : g_bad_polls
      $error("POLLS must lie in 0 to 255.");
   end
   if (`DPS_WP_CYC > 15 || `DPS_ACC_CYC > 15 || `DPS_GAP_CYC > 1)
   begin : g_bad_timing
      $error("Timing counts exceed what the counter or gap state serves.");
   end

   // ========================================================================
   // State
   typedef struct packed
   {
      dps_state_t        st;
      dps_op_t           op;
      logic [3:0]        cnt;
      logic [2:0]        idx;
      logic              val;
      logic [7:0]        polls;
      logic              granted;
      logic [DATA_W-1:0] rdata;
      logic              sel_n;
      logic              oe_n;
      logic              rw_n;
      logic              doe;
   } dps_host_t;

   localparam logic [3:0] WP_LAST  = 4'(`DPS_WP_CYC - 1);
   localparam logic [3:0] ACC_LAST = 4'(`DPS_ACC_CYC - 1);
   localparam logic [7:0] POLLS_L  = 8'(POLLS);

   dps_host_t q;
   dps_host_t d;

   // Opens a write strobe for the selected flag with the held value.
   function automatic dps_host_t start_write(input dps_host_t s);
      dps_host_t r;
      r       = s;
      r.st    = DPS_ST_WRITE;
      r.sel_n = 1'b0;
      r.rw_n  = 1'b0;
      r.oe_n  = 1'b1;
      r.doe   = 1'b1;
      r.cnt   = WP_LAST;
      return r;
   endfunction

   // Opens a read of the selected flag.
   function automatic dps_host_t start_read(input dps_host_t s);
      dps_host_t r;
      r       = s;
      r.st    = DPS_ST_READ;
      r.sel_n = 1'b0;
      r.oe_n  = 1'b0;
      r.rw_n  = 1'b1;
      r.doe   = 1'b0;
      r.cnt   = ACC_LAST;
      return r;
   endfunction

   // ========================================================================
   // Next state. Every access lowers only the flag select; the memory
   // enable never falls, so the flag space is used without touching the
   // array and the device port idles in standby between accesses.
   always_comb
   begin
      d = q;
      case (q.st)
         DPS_ST_IDLE:
         begin
            if (cmd_valid_i)
            begin
               d.op      = cmd_op_i;
               d.idx     = (cmd_op_i == DPS_OP_INIT) ? 3'h0 : cmd_idx_i;
               d.val     = (cmd_op_i == DPS_OP_ACQ) ? `DPS_TAKE : `DPS_FREE; // see [RQ5]
               d.polls   = POLLS_L;
               d.granted = 1'b0;
               d         = start_write(d); // see [RQ2]
            end
         end
         DPS_ST_WRITE:
         begin
            if (q.cnt == 4'h0)
            begin
               // Strobes rise first; data is held one more cycle as hold time.
               d.st    = DPS_ST_WREC;
               d.sel_n = 1'b1;
               d.rw_n  = 1'b1;
            end
            else
               d.cnt = q.cnt - 4'h1;
         end
         DPS_ST_WREC:
         begin
            d.doe = 1'b0;
            if (q.op == DPS_OP_ACQ && q.val == `DPS_TAKE)
               d = start_read(d); // see [RQ14]
            else if (q.op == DPS_OP_INIT && q.idx != `DPS_LAST_IDX)
            begin
               d.idx = q.idx + 3'h1;
               d     = start_write(d); // see [RQ17]
            end
            else
               d.st = DPS_ST_FIN;
         end
         DPS_ST_READ:
         begin
            if (q.cnt == 4'h0)
            begin
               d.rdata   = data_i;
               d.granted = (data_i[`DPS_FLAG_BIT] == `DPS_TAKE);
               d.st      = DPS_ST_GAP;
               d.sel_n   = 1'b1; // see [RQ12]
               d.oe_n    = 1'b1;
            end
            else
               d.cnt = q.cnt - 4'h1;
         end
         DPS_ST_GAP:
         begin
            // Both strobes are high here, so the next read relatches the flag.
            if (q.granted)
               d.st = DPS_ST_FIN;
            else if (q.polls != 8'h00)
            begin
               d.polls = q.polls - 8'h01;
               d       = start_read(d); // see [RQ15]
            end
            else
            begin
               // Withdraw the stale request so it cannot seize the token later.
               d.val = `DPS_FREE;
               d     = start_write(d); // see [RQ15]
            end
         end
         DPS_ST_FIN:
            d.st = DPS_ST_IDLE;
         default:
            d.st = DPS_ST_IDLE;
      endcase
   end

   // ========================================================================
   // State register with synchronous reset.
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         q         <= '0;
         q.st      <= DPS_ST_IDLE;
         q.op      <= DPS_OP_ACQ;
         q.sel_n   <= 1'b1;
         q.oe_n    <= 1'b1;
         q.rw_n    <= 1'b1;
         q.val     <= `DPS_FREE;
      end
      else
         q <= d;
   end

   // ========================================================================
   // Outputs. Only the low three address bits carry the flag index.
   assign cmd_ready_o            = (q.st == DPS_ST_IDLE);
   assign done_o                 = (q.st == DPS_ST_FIN);
   assign granted_o              = q.granted;
   assign flag_data_o            = q.rdata;
   assign token_space_select_n_o = q.sel_n;
   assign mem_ce_n_o             = 1'b1; // see [RQ20]
   assign oe_n_o                 = q.oe_n;
   assign rw_n_o                 = q.rw_n;
   assign addr_o                 = {{(ADDR_W-3){1'b0}}, q.idx};
   assign data_o                 = {DATA_W{q.val}};
   assign data_oe_o              = q.doe;

   // ========================================================================
   // Checks on the pin sequence.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   ce_held_high_a: assert property (!token_space_select_n_o |-> mem_ce_n_o) // see [RQ20]
      else $error("Memory enable low during a flag access.");
   read_strobe_a: assert property (!oe_n_o |-> !token_space_select_n_o && rw_n_o && !data_oe_o) // see [RQ2]
      else $error("Output enable low outside a flag read.");
   write_strobe_a: assert property (!rw_n_o |-> !token_space_select_n_o && data_oe_o && oe_n_o) // see [RQ2]
      else $error("Write strobe without select and driven data.");
   read_length_a: assert property ($fell(oe_n_o) |-> !oe_n_o [*4] ##1 oe_n_o) // see [RQ12]
      else $error("Read strobe not released after the access time.");
   write_length_a: assert property ($fell(rw_n_o) |-> !rw_n_o [*4] ##1 (rw_n_o && data_oe_o)) // see [RQ2]
      else $error("Write strobe width or data hold wrong.");
   take_then_read_a: assert property ($rose(rw_n_o) && data_o[0] == 1'b0 |=> $fell(oe_n_o)) // see [RQ14]
      else $error("A zero write is not followed by a read back.");
   read_after_write_a: assert property ($fell(oe_n_o) |-> $past(q.st) inside {DPS_ST_WREC, DPS_ST_GAP}) // see [RQ14]
      else $error("Read opened without a preceding request.");
   withdraw_fail_a: assert property (q.st == DPS_ST_GAP && !q.granted && q.polls == 8'h00 |=> !rw_n_o && data_o[0]) // see [RQ15]
      else $error("Failed request neither polled nor withdrawn.");
   init_all_a: assert property (q.op == DPS_OP_INIT && done_o |-> $past(addr_o[2:0], 2) == 3'h7 && data_o[0]) // see [RQ17]
      else $error("Initialisation did not reach the last flag.");
   done_pulse_a: assert property (done_o |=> !done_o && cmd_ready_o)
      else $error("Done is not a single pulse.");

   acq_won_c: cover property (done_o && q.op == DPS_OP_ACQ && granted_o);
   acq_lost_c: cover property (done_o && q.op == DPS_OP_ACQ && !granted_o);
   init_done_c: cover property (done_o && q.op == DPS_OP_INIT);
   release_done_c: cover property (done_o && q.op == DPS_OP_REL);

endmodule

// File: dps_map.svh
// Pin timing, field positions and reset values for the semaphore host controller.
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

// System clock period in picoseconds (250 MHz).
`define DPS_CLK_PS        4000
// Least width of the write strobe, in nanoseconds.
`define DPS_T_WP_NS       15
// Longest read access time from select and output enable, in nanoseconds.
`define DPS_T_ACC_NS      15
// Least time both strobes stay high between two accesses, in nanoseconds.
`define DPS_T_GAP_NS      4
// Derived cycle counts; least times and access times round up.
`define DPS_WP_CYC        ((`DPS_T_WP_NS * 1000 + `DPS_CLK_PS - 1) / `DPS_CLK_PS)
`define DPS_ACC_CYC       ((`DPS_T_ACC_NS * 1000 + `DPS_CLK_PS - 1) / `DPS_CLK_PS)
`define DPS_GAP_CYC       ((`DPS_T_GAP_NS * 1000 + `DPS_CLK_PS - 1) / `DPS_CLK_PS)
// The flag is written through data bit zero and read back there as well.
`define DPS_FLAG_BIT      0
// Number of flags and the index of the last one.
`define DPS_NUM_FLAGS     8
`define DPS_LAST_IDX      3'h7
// Default number of extra polls after a failed request before withdrawing.
`define DPS_POLLS_DEF     4
// Flag values: zero requests or owns, one releases or reads free.
`define DPS_TAKE          1'b0
`define DPS_FREE          1'b1

`endif

// File: dps_pkg.sv
// Types shared by the semaphore host controller.
package dps_pkg;

   // Controller states, Gray coded along write, recover, read, gap.
   typedef enum logic [2:0]
   {
      DPS_ST_IDLE  = 3'h0,
      DPS_ST_WRITE = 3'h1,
      DPS_ST_WREC  = 3'h3,
      DPS_ST_READ  = 3'h2,
      DPS_ST_GAP   = 3'h6,
      DPS_ST_FIN   = 3'h7
   } dps_state_t;

   // User commands.
   typedef enum logic [1:0]
   {
      DPS_OP_ACQ  = 2'h0,
      DPS_OP_REL  = 2'h1,
      DPS_OP_INIT = 2'h2
   } dps_op_t;

endpackage

// File: dps_dev_model.sv
// Behavioural flag bank that stands on the far side of the host controller.
`timescale 1ns/1ps
// =======
// Flag bank model; port 0 faces the host, port 1 the bench.
module dps_dev_model
#(
   parameter int W      = 18,
   parameter int AW     = 13,
   parameter int ACC_NS = 14
)
(
   input  wire logic [1:0]         ce_n_i,
   input  wire logic [1:0]         sel_n_i,
   input  wire logic [1:0]         oe_n_i,
   input  wire logic [1:0]         rw_n_i,
   input  wire logic [1:0][AW-1:0] addr_i,
   input  wire logic [1:0][W-1:0]  din_i,
   output wire logic [1:0][W-1:0]  dout_o,
   output wire logic [1:0]         stby_o
);
   // Latches start unknown, so a port never wins a flag until the far port has written one to it.
   logic [7:0] own_q [2];
   logic [7:0] req_q [2];

   // A zero requests, a one releases and hands over to a pending request.
   task automatic do_wr(input int p, input logic [2:0] i, input logic v);
      if ($isunknown({i, v}))
         return;
      if (v == 1'b0)
      begin
         req_q[p][i] = 1'b1;
         if (own_q[1-p][i] === 1'b0)
            own_q[p][i] = 1'b1;
      end
      else if (own_q[p][i] !== 1'b0)
      begin
         req_q[p][i]   = 1'b0;
         own_q[p][i]   = 1'b0;
         own_q[1-p][i] = req_q[1-p][i];
      end
      else
         req_q[p][i] = 1'b0;
   endtask

   for (genvar p = 0; p < 2; p++)
   begin : g_port
      wire  logic wr = ce_n_i[p] & ~sel_n_i[p] & ~rw_n_i[p];
      wire  logic rd = ce_n_i[p] & ~sel_n_i[p] & ~oe_n_i[p];
      logic       lat_q = 1'b1;
      logic       vis_q = 1'b0;
      // The write lands as the strobe closes; only low address bits and bit 0 count.
      always @(negedge wr)
         do_wr(p, addr_i[p][2:0], din_i[p][0]);
      // The value is frozen at select, so far writes cannot tear a read.
      always @(posedge rd)
      begin
         lat_q = ~own_q[p][addr_i[p][2:0]];
         vis_q = 1'b0;
         #(ACC_NS) vis_q = rd;
      end
      always @(negedge rd)
         vis_q = 1'b0;
      // Released pins show the inverse so a late sample is caught; no wait output.
      assign dout_o[p] = vis_q ? {W{lat_q}} : {W{~lat_q}};
      assign stby_o[p] = ce_n_i[p] & sel_n_i[p];
   end
endmodule

// File: tb.sv
// Self-checking bench for the semaphore host controller.
`timescale 1ns/1ps
// =======
// Bench top: host on model port 0, bench drives port 1.
module tb
   import dps_pkg::*;
;
   localparam int DW = 18;
   localparam int AW = 13;
   localparam int NP = 1; // One extra poll keeps the refusal walk short.
   logic             clk_sys_i = 1'b0;
   logic             sys_rst_i = 1'b1;
   logic             cmd_valid = 1'b0;
   dps_op_t          cmd_op    = DPS_OP_ACQ;
   logic [2:0]       cmd_idx   = 3'h0;
   logic             ready, done, granted, sel_n, ce_n, oe_n, rw_n, d_oe, q;
   logic [DW-1:0]    flag_d, d_o;
   logic [AW-1:0]    addr;
   logic             r_sel_n = 1'b1, r_oe_n = 1'b1, r_rw_n = 1'b1;
   logic [AW-1:0]    r_addr  = 13'h0;
   logic [DW-1:0]    r_din   = 18'h3FFFF;
   wire  logic [1:0][DW-1:0] dout;
   wire  logic [1:0] stby;
   // The shared host data wire: host when it drives, else the bank.
   wire  logic [DW-1:0] l_bus = d_oe ? d_o : dout[0];
   int               bad_count = 0, comparisons = 0, cyc, rd_run = 0;

   always #2 clk_sys_i = ~clk_sys_i;

   dps_host #(.DATA_W(DW), .ADDR_W(AW), .POLLS(NP)) DUT (.clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_idx_i(cmd_idx),
      .cmd_ready_o(ready), .done_o(done), .granted_o(granted), .flag_data_o(flag_d),
      .token_space_select_n_o(sel_n), .mem_ce_n_o(ce_n), .oe_n_o(oe_n), .rw_n_o(rw_n),
      .addr_o(addr), .data_o(d_o), .data_oe_o(d_oe), .data_i(l_bus));
   dps_dev_model #(.W(DW), .AW(AW), .ACC_NS(14)) dev (.ce_n_i({1'b1, ce_n}),
      .sel_n_i({r_sel_n, sel_n}), .oe_n_i({r_oe_n, oe_n}), .rw_n_i({r_rw_n, rw_n}),
      .addr_i({r_addr, addr}), .din_i({r_din, l_bus}), .dout_o(dout), .stby_o(stby));

   task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop;
      $display("Summary: %0d comparisons, %0d mismatches", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Polling reads must be split by a gap, and memory enable stays off.
   always @(posedge clk_sys_i)
   begin
      rd_run <= (!sel_n && !oe_n) ? rd_run + 1 : 0;
      if (!sys_rst_i && (rd_run > 4 || (!sel_n && ce_n !== 1'b1)))
      begin
         bad_count++;
         $display("CHECK FAILED strobe run expected at most 4 seen %0d", rd_run);
      end
   end

   // One host command; cyc counts cycles from the take edge to done.
   task automatic run_cmd(input dps_op_t op, input logic [2:0] idx);
      @(posedge clk_sys_i);
      cmd_valid <= 1'b1;
      cmd_op    <= op;
      cmd_idx   <= idx;
      @(posedge clk_sys_i);
      cmd_valid <= 1'b0;
      #1;
      chk("first strobe", 18'h0, {15'h0, sel_n, rw_n, ~d_oe});
      chk("write word", (op == DPS_OP_ACQ) ? 18'h0 : 18'h3FFFF, d_o);
      if (op != DPS_OP_INIT)
         chk("address", {15'h0, idx}, {5'h0, addr});
      cyc = 1;
      while (done !== 1'b1 && cyc < 300)
      begin
         @(posedge clk_sys_i);
         #1;
         cyc++;
      end
      // A command that never ends is counted here instead of passing quietly.
      chk("done pulse", 18'h1, {17'h0, done});
   endtask

   // Bench-side access on port 1, strobes held four cycles.
   task automatic r_acc(input logic wr, input logic [2:0] idx, input logic v);
      @(posedge clk_sys_i);
      r_sel_n <= 1'b0;
      r_rw_n  <= ~wr;
      r_oe_n  <= wr;
      r_addr  <= {10'h3FF, idx};
      r_din   <= {DW{v}};
      repeat (4) @(posedge clk_sys_i);
      q = dout[1][0];
      if (!wr)
         chk("far word", {DW{q}}, dout[1]);
      r_sel_n <= 1'b1;
      r_rw_n  <= 1'b1;
      r_oe_n  <= 1'b1;
   endtask

   // Far side requests the flag and reports whether it got it.
   task automatic far_try(input logic [2:0] idx, input string what, input logic exp);
      r_acc(1'b1, idx, 1'b0);
      r_acc(1'b0, idx, 1'b0);
      chk(what, {17'h0, exp}, {17'h0, q});
      r_acc(1'b1, idx, 1'b1);
   endtask

   task automatic t_start;
      chk("idle pins", 18'hFC,
          {10'h0, ready, sel_n, ce_n, oe_n, rw_n, stby[0], granted, d_oe});
      for (int i = 0; i < 8; i++)
         r_acc(1'b1, i[2:0], 1'b1);
      run_cmd(DPS_OP_INIT, 3'h0);
      for (int i = 0; i < 8; i++)
         far_try(i[2:0], "far after init", 1'b0);
   endtask

   task automatic t_acq_pass;
      run_cmd(DPS_OP_ACQ, 3'h3);
      chk("grant time", 18'h0B, DW'(cyc));
      chk("granted", 18'h1, {17'h0, granted});
      chk("read word", 18'h0, flag_d);
      r_acc(1'b1, 3'h3, 1'b0);
      run_cmd(DPS_OP_REL, 3'h3);
      r_acc(1'b0, 3'h3, 1'b0);
      chk("handover", 18'h0, {17'h0, q});
      r_acc(1'b1, 3'h3, 1'b1);
   endtask

   task automatic t_refuse;
      r_acc(1'b1, 3'h5, 1'b0);
      run_cmd(DPS_OP_ACQ, 3'h5);
      chk("refusal time", DW'(11 + 5 * NP + 5), DW'(cyc));
      chk("refused", 18'h0, {17'h0, granted});
      chk("read word", 18'h3FFFF, flag_d);
      r_acc(1'b1, 3'h5, 1'b1);
      far_try(3'h5, "withdrawn", 1'b0);
   endtask

   task automatic t_back;
      run_cmd(DPS_OP_ACQ, 3'h7);
      chk("granted 7", 18'h1, {17'h0, granted});
      run_cmd(DPS_OP_ACQ, 3'h0);
      chk("granted 0", 18'h1, {17'h0, granted});
      far_try(3'h7, "held 7", 1'b1);
      run_cmd(DPS_OP_REL, 3'h7);
      run_cmd(DPS_OP_REL, 3'h0);
      far_try(3'h0, "freed 0", 1'b0);
   endtask

   initial
   begin
      repeat (6) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      t_start;
      t_acq_pass;
      t_refuse;
      t_back;
      report_and_stop;
   end

   // Whole run is under 2000 cycles, so this only fires on a hang.
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      bad_count++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      report_and_stop;
   end
endmodule
